/* File: verilog/lts_line_timing.sv */
// line timing pulse control: registers, line reference and pulses
//
// Operation
// [R1] sync output start and end, 10-bit delays
// [R2] low delay bytes at 0x0c and 0x0e
// [R3] upper two bits at 0x0d and 0x0f
// [R4] upper bits 15..10 ignored, read zero
// [R5] restore pulse start delay at 0x12/0x13
// [R6] loop filter adjust byte, resets to zero
// [R7] host should program filter adjust 0x20
// [R8] detect window byte, resets to 0xdd
// [R9] sync outside window counted as missing
// [R10] delays count clocks, apply next line
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module lts_line_timing #(
	parameter int LINE_LEN = lts_pkg::LINE_CYCLES, // nominal line in clocks
	parameter int RESTORE_LEN = lts_pkg::RESTORE_WIDTH_CYCLES // restore width
) (
	input wire logic clk, // system clock, 100 MHz
	input wire logic rst_b, // synchronous reset, active low
	input wire logic sync_in, // incoming horizontal sync pin, high
	input wire logic [7:0] address, // avalon byte address
	input wire logic read, // avalon read request
	input wire logic write, // avalon write request
	input wire logic [31:0] writedata, // avalon write data
	input wire logic [3:0] byteenable, // avalon byte lanes
	output logic [31:0] readdata, // avalon read data
	output logic waitrequest, // avalon wait, low on answer
	output logic ext_sync_pulse, // external horizontal sync output
	output logic black_level_restore_pulse, // internal restore pulse
	output logic [7:0] loop_filter_adjust, // pll time constant trim
	output logic line_locked // last line ended on a valid sync
);
	localparam int CW = lts_pkg::CNT_W;
	localparam int DW = lts_pkg::DELAY_W;
	localparam logic [CW-1:0] LINE_C = CW'(LINE_LEN);
	localparam logic [CW-1:0] REST_C = CW'(RESTORE_LEN);

	// all state of the block
	typedef struct packed {
		logic [7:0] start_lo; // sync start low byte
		logic [1:0] start_hi; // sync start upper bits
		logic [7:0] end_lo; // sync end low byte
		logic [1:0] end_hi; // sync end upper bits
		logic [7:0] filt; // loop filter adjust
		logic [7:0] win; // sync detect window
		logic [7:0] rest_lo; // restore start low byte
		logic [1:0] rest_hi; // restore start upper bits
		logic [DW-1:0] start_sh; // start delay in use this line
		logic [DW-1:0] end_sh; // end delay in use this line
		logic [DW-1:0] rest_sh; // restore delay in use this line
		logic [CW-1:0] cnt; // clocks since line reference
		logic [7:0] miss; // missing sync count, saturating
		logic locked; // line ended on an accepted sync
		logic waitreq; // avalon waitrequest
		logic [31:0] rdata; // avalon read data
	} lts_state_type;

	lts_state_type s_q;
	lts_state_type s_d;

	// combinational helpers
	logic [5:0] idx; // register word index
	logic acc; // a bus request is answered this edge
	logic wr; // accepted write with the low lane on
	logic sync_rise; // synchronised incoming sync edge
	logic [CW-1:0] win_lo; // earliest accepted sync count
	logic [CW-1:0] win_hi; // latest accepted sync count
	logic line_ref; // a new line starts at this edge
	logic miss_ev; // the window closed without a sync
	logic [CW-1:0] start_c; // widened start delay
	logic [CW-1:0] end_c; // widened end delay
	logic [CW-1:0] rest_c; // widened restore delay
	logic [CW-1:0] rest_stop; // restore fall count

	// incoming sync is a pin; two flops before anything looks at it
	lts_sync_edge u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.pin_in(sync_in),
		.rise(sync_rise)
	);

	assign idx = address[7:2];
	// one answer per request: waitrequest drops for a single cycle
	assign acc = (read | write) & s_q.waitreq;
	assign wr = acc & write & byteenable[0];

	// window straddles the nominal line end by the programmed count
	assign win_lo = LINE_C - CW'(s_q.win);
	assign win_hi = LINE_C + CW'(s_q.win);
	// a sync before the window is ignored and the line runs on
	assign line_ref = (sync_rise & (s_q.cnt >= win_lo)) | miss_ev; // [R9]
	assign miss_ev = (s_q.cnt == win_hi) & ~sync_rise; // [R9]

	assign start_c = CW'(s_q.start_sh);
	assign end_c = CW'(s_q.end_sh);
	assign rest_c = CW'(s_q.rest_sh);
	// the carry is dropped on purpose: a start near the counter top has no use
	assign rest_stop = CW'(rest_c + REST_C);

	// next state of registers, line counter and bus answer
	always_comb begin
		s_d = s_q;
		s_d.waitreq = ~acc;
		// register writes; upper bits of the high bytes drop here
		if (wr) begin
			unique case (idx)
				lts_pkg::IDX_SYNC_START_LOW: begin
					s_d.start_lo = writedata[7:0]; // [R2]
				end
				lts_pkg::IDX_SYNC_START_HIGH: begin
					s_d.start_hi = writedata[1:0]; // [R3] [R4]
				end
				lts_pkg::IDX_SYNC_END_LOW: begin
					s_d.end_lo = writedata[7:0]; // [R2]
				end
				lts_pkg::IDX_SYNC_END_HIGH: begin
					s_d.end_hi = writedata[1:0]; // [R3] [R4]
				end
				lts_pkg::IDX_LOOP_FILTER_ADJUST: begin
					s_d.filt = writedata[7:0]; // [R6]
				end
				lts_pkg::IDX_SYNC_DETECT_WINDOW: begin
					s_d.win = writedata[7:0]; // [R8]
				end
				lts_pkg::IDX_RESTORE_START_LOW: begin
					s_d.rest_lo = writedata[7:0]; // [R5]
				end
				lts_pkg::IDX_RESTORE_START_HIGH: begin
					s_d.rest_hi = writedata[1:0]; // [R5] [R4]
				end
				default: begin
					// unmapped: write ignored; a status write clears the miss count below
				end
			endcase
		end
		// read data; everything above the field reads zero
		if (acc & read) begin
			unique case (idx)
				lts_pkg::IDX_SYNC_START_LOW: s_d.rdata = {24'h0, s_q.start_lo};
				lts_pkg::IDX_SYNC_START_HIGH: s_d.rdata = {30'h0, s_q.start_hi}; // [R4]
				lts_pkg::IDX_SYNC_END_LOW: s_d.rdata = {24'h0, s_q.end_lo};
				lts_pkg::IDX_SYNC_END_HIGH: s_d.rdata = {30'h0, s_q.end_hi}; // [R4]
				lts_pkg::IDX_LOOP_FILTER_ADJUST: s_d.rdata = {24'h0, s_q.filt};
				lts_pkg::IDX_SYNC_DETECT_WINDOW: s_d.rdata = {24'h0, s_q.win};
				lts_pkg::IDX_RESTORE_START_LOW: s_d.rdata = {24'h0, s_q.rest_lo};
				lts_pkg::IDX_RESTORE_START_HIGH: s_d.rdata = {30'h0, s_q.rest_hi}; // [R4]
				lts_pkg::IDX_LINE_STATUS: s_d.rdata = {23'h0, s_q.locked, s_q.miss};
				default: s_d.rdata = 32'h0;
			endcase
		end
		// line counter restarts at every line reference
		if (line_ref) begin
			s_d.cnt = '0; // [R10]
			s_d.locked = ~miss_ev;
			// new delays take hold only at a line boundary
			s_d.start_sh = {s_q.start_hi, s_q.start_lo}; // [R10] [R1]
			s_d.end_sh = {s_q.end_hi, s_q.end_lo}; // [R10] [R1]
			s_d.rest_sh = {s_q.rest_hi, s_q.rest_lo}; // [R10] [R5]
		end else begin
			s_d.cnt = s_q.cnt + CW'(1); // [R10]
		end
		// missing count: a write to status clears, a new miss wins
		if (wr & (idx == lts_pkg::IDX_LINE_STATUS)) begin
			s_d.miss = 8'h0;
		end
		if (miss_ev) begin
			if (wr & (idx == lts_pkg::IDX_LINE_STATUS)) begin
				s_d.miss = 8'h01; // [R9]
			end else if (s_q.miss != 8'hff) begin
				s_d.miss = s_q.miss + 8'h01; // [R9]
			end
		end
	end

	// state register with documented reset values
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.start_lo <= lts_pkg::RST_SYNC_START_LOW;
			s_q.start_hi <= lts_pkg::RST_SYNC_START_HIGH;
			s_q.end_lo <= lts_pkg::RST_SYNC_END_LOW;
			s_q.end_hi <= lts_pkg::RST_SYNC_END_HIGH;
			s_q.filt <= lts_pkg::RST_LOOP_FILTER_ADJUST; // [R6]
			s_q.win <= lts_pkg::RST_SYNC_DETECT_WINDOW; // [R8]
			s_q.rest_lo <= lts_pkg::RST_RESTORE_START_LOW;
			s_q.rest_hi <= lts_pkg::RST_RESTORE_START_HIGH;
			s_q.start_sh <= {lts_pkg::RST_SYNC_START_HIGH, lts_pkg::RST_SYNC_START_LOW};
			s_q.end_sh <= {lts_pkg::RST_SYNC_END_HIGH, lts_pkg::RST_SYNC_END_LOW};
			s_q.rest_sh <= {lts_pkg::RST_RESTORE_START_HIGH, lts_pkg::RST_RESTORE_START_LOW};
			s_q.waitreq <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// external sync pulse between the two delays
	lts_pulse_gen #(
		.CW(CW)
	) u_ext_sync (
		.clk(clk),
		.rst_b(rst_b),
		.line_cnt(s_q.cnt),
		.start_cnt(start_c),
		.stop_cnt(end_c),
		.pulse_q(ext_sync_pulse)
	); // [R1]

	// restore pulse: fixed width, it falls RESTORE_LEN counts after its start
	lts_pulse_gen #(
		.CW(CW)
	) u_restore (
		.clk(clk),
		.rst_b(rst_b),
		.line_cnt(s_q.cnt),
		.start_cnt(rest_c),
		.stop_cnt(rest_stop),
		.pulse_q(black_level_restore_pulse)
	); // [R5]

	// outputs straight from state flops
	assign readdata = s_q.rdata;
	assign waitrequest = s_q.waitreq;
	assign loop_filter_adjust = s_q.filt; // [R6]
	assign line_locked = s_q.locked;

	// checks run on the system clock, idle in reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	property p_sync_rise;
		$rose(ext_sync_pulse) |-> $past(s_q.cnt) == CW'($past(s_q.start_sh));
	endproperty
	a_sync_rise: assert property (p_sync_rise) else $error("sync rose off start"); // [R1]

	property p_low_write;
		wr && idx == lts_pkg::IDX_SYNC_END_LOW |=> s_q.end_lo == $past(writedata[7:0]);
	endproperty
	a_low_write: assert property (p_low_write) else $error("end low not written"); // [R2]

	property p_high_write;
		wr && idx == lts_pkg::IDX_SYNC_START_HIGH |=> s_q.start_hi == $past(writedata[1:0]);
	endproperty
	a_high_write: assert property (p_high_write) else $error("start high not written"); // [R3]

	property p_high_zero;
		acc && read && (idx == lts_pkg::IDX_SYNC_END_HIGH) |=> !waitrequest && readdata[31:2] == 30'h0;
	endproperty
	a_high_zero: assert property (p_high_zero) else $error("upper bits read nonzero"); // [R4]

	property p_rest_rise;
		$rose(black_level_restore_pulse) |-> $past(s_q.cnt) == CW'($past(s_q.rest_sh));
	endproperty
	a_rest_rise: assert property (p_rest_rise) else $error("restore rose off start"); // [R5]

	property p_filt_reset;
		$rose(rst_b) |-> loop_filter_adjust == lts_pkg::RST_LOOP_FILTER_ADJUST
			&& s_q.win == lts_pkg::RST_SYNC_DETECT_WINDOW;
	endproperty
	a_filt_reset: assert property (p_filt_reset) else $error("bad reset values"); // [R6]

	property p_win_hold;
		!(wr && idx == lts_pkg::IDX_SYNC_DETECT_WINDOW) ##1 1 |-> $stable(s_q.win);
	endproperty
	a_win_hold: assert property (p_win_hold) else $error("window changed unwritten"); // [R8]

	property p_miss_count;
		miss_ev && !wr && s_q.miss != 8'hff |=> s_q.miss == $past(s_q.miss) + 8'h01 && !line_locked;
	endproperty
	a_miss_count: assert property (p_miss_count) else $error("miss not counted"); // [R9]

	property p_shadow_line;
		!line_ref |=> $stable(s_q.start_sh) && $stable(s_q.rest_sh);
	endproperty
	a_shadow_line: assert property (p_shadow_line) else $error("delay moved midline"); // [R10]

	// each request gets exactly one cycle of waitrequest low
	property p_one_answer;
		acc |=> !waitrequest ##1 waitrequest;
	endproperty
	a_one_answer: assert property (p_one_answer) else $error("bus answer not single"); // avalon port handshake, chosen here

	// low byte of the sync start delay lands whole
	property p_start_lo_wr;
		wr && idx == lts_pkg::IDX_SYNC_START_LOW |=> s_q.start_lo == $past(writedata[7:0]);
	endproperty
	a_start_lo_wr: assert property (p_start_lo_wr) else $error("start low lost"); // [R2]

	// upper two bits of the sync end delay come from the next address
	property p_end_hi_wr;
		wr && idx == lts_pkg::IDX_SYNC_END_HIGH |=> s_q.end_hi == $past(writedata[1:0]);
	endproperty
	a_end_hi_wr: assert property (p_end_hi_wr) else $error("end high lost"); // [R3]

	// upper byte of the start delay never reads back above bit 1
	property p_start_hi_zero;
		acc && read && (idx == lts_pkg::IDX_SYNC_START_HIGH) |=> readdata[31:2] == 30'h0;
	endproperty
	a_start_hi_zero: assert property (p_start_hi_zero) else $error("start high bits set"); // [R4]

	// sync output falls exactly at the end count; a reset drop is excluded
	property p_sync_fall;
		$fell(ext_sync_pulse) && $past(rst_b) |-> $past(s_q.cnt) == CW'($past(s_q.end_sh));
	endproperty
	a_sync_fall: assert property (p_sync_fall) else $error("sync fell off end"); // [R1]

	// restore pulse drops after its fixed width; a reset drop is excluded
	property p_rest_fall;
		$fell(black_level_restore_pulse) && $past(rst_b) |-> $past(s_q.cnt) == $past(rest_stop);
	endproperty
	a_rest_fall: assert property (p_rest_fall) else $error("restore fell off width"); // [R5]

	// restore delay low byte lands in its own register
	property p_rest_lo_wr;
		wr && idx == lts_pkg::IDX_RESTORE_START_LOW |=> s_q.rest_lo == $past(writedata[7:0]);
	endproperty
	a_rest_lo_wr: assert property (p_rest_lo_wr) else $error("restore low lost"); // [R5]

	// restore delay upper bits keep only the two live positions
	property p_rest_hi_wr;
		wr && idx == lts_pkg::IDX_RESTORE_START_HIGH |=> s_q.rest_hi == $past(writedata[1:0]);
	endproperty
	a_rest_hi_wr: assert property (p_rest_hi_wr) else $error("restore high lost"); // [R5]

	// filter trim output follows a write at once
	property p_filt_wr;
		wr && idx == lts_pkg::IDX_LOOP_FILTER_ADJUST |=> loop_filter_adjust == $past(writedata[7:0]);
	endproperty
	a_filt_wr: assert property (p_filt_wr) else $error("filter trim not written"); // [R6]

	// window byte is stored as written
	property p_win_wr;
		wr && idx == lts_pkg::IDX_SYNC_DETECT_WINDOW |=> s_q.win == $past(writedata[7:0]);
	endproperty
	a_win_wr: assert property (p_win_wr) else $error("window not written"); // [R8]

	// an in-window sync marks the line as locked
	property p_lock_ref;
		line_ref && !miss_ev |=> line_locked;
	endproperty
	a_lock_ref: assert property (p_lock_ref) else $error("lock not set"); // [R9]

	// a miss restarts the line from count zero and drops the lock
	property p_miss_restart;
		miss_ev |=> s_q.cnt == '0 && !line_locked;
	endproperty
	a_miss_restart: assert property (p_miss_restart) else $error("miss did not restart line"); // [R9]

	// between references the count steps by one; reset edges are left out
	property p_cnt_step;
		rst_b && !line_ref |=> s_q.cnt == $past(s_q.cnt) + CW'(1);
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("count skipped"); // [R10]
endmodule : lts_line_timing

/* File: verilog/lts_pkg.sv */
// constants for the line timing pulse control block
package lts_pkg;
	// register word indices; byte address is four times the index
	localparam logic [5:0] IDX_SYNC_START_LOW = 6'h0c;
	localparam logic [5:0] IDX_SYNC_START_HIGH = 6'h0d;
	localparam logic [5:0] IDX_SYNC_END_LOW = 6'h0e;
	localparam logic [5:0] IDX_SYNC_END_HIGH = 6'h0f;
	localparam logic [5:0] IDX_LOOP_FILTER_ADJUST = 6'h10;
	localparam logic [5:0] IDX_SYNC_DETECT_WINDOW = 6'h11;
	localparam logic [5:0] IDX_RESTORE_START_LOW = 6'h12;
	localparam logic [5:0] IDX_RESTORE_START_HIGH = 6'h13;
	localparam logic [5:0] IDX_LINE_STATUS = 6'h18;
	// reset values
	localparam logic [7:0] RST_SYNC_START_LOW = 8'h3b;
	localparam logic [1:0] RST_SYNC_START_HIGH = 2'h3;
	localparam logic [7:0] RST_SYNC_END_LOW = 8'h20;
	localparam logic [1:0] RST_SYNC_END_HIGH = 2'h0;
	localparam logic [7:0] RST_LOOP_FILTER_ADJUST = 8'h00;
	localparam logic [7:0] RST_SYNC_DETECT_WINDOW = 8'hdd;
	localparam logic [7:0] RST_RESTORE_START_LOW = 8'h3f;
	localparam logic [1:0] RST_RESTORE_START_HIGH = 2'h0;
	// field layout
	localparam int DELAY_W = 10;
	localparam int HIGH_W = 2;
	localparam int CNT_W = 13;
	localparam int STAT_LOCK_BIT = 8;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int LINE_NS = 63556;
	localparam int LINE_CYCLES = LINE_NS / CLK_PERIOD_NS;
	localparam int RESTORE_WIDTH_NS = 2000;
	localparam int RESTORE_WIDTH_CYCLES =
		(RESTORE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : lts_pkg

/* File: verilog/lts_sync_edge.sv */
// two-stage synchroniser with rising edge detect for a pin input
`timescale 1ns/1ps
module lts_sync_edge (
	input wire logic clk, // system clock
	input wire logic rst_b, // synchronous reset, active low
	input wire logic pin_in, // asynchronous pin level
	output logic rise // one-cycle pulse on a synchronised rise
);
	// all state of the synchroniser
	typedef struct packed {
		logic meta; // first stage, read only by the second
		logic stable; // second stage
		logic last; // delayed copy for the edge detect
	} lts_sync_state_type;

	lts_sync_state_type s_q;
	lts_sync_state_type s_d;

	// next state: shift the pin through the stages
	always_comb begin
		s_d = s_q;
		s_d.meta = pin_in;
		s_d.stable = s_q.meta;
		s_d.last = s_q.stable;
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// edge seen only past the second stage
	assign rise = s_q.stable & ~s_q.last;
endmodule : lts_sync_edge

/* File: verilog/lts_pulse_gen.sv */
// line-relative pulse built from a start and a stop count
`timescale 1ns/1ps
module lts_pulse_gen #(
	parameter int CW = 13 // width of the line count
) (
	input wire logic clk, // system clock
	input wire logic rst_b, // synchronous reset, active low
	input wire logic [CW-1:0] line_cnt, // cycles since line reference
	input wire logic [CW-1:0] start_cnt, // count at which the pulse rises
	input wire logic [CW-1:0] stop_cnt, // count at which the pulse falls
	output logic pulse_q // pulse, straight from a flop
);
	// all state of the generator
	typedef struct packed {
		logic pulse; // pulse level
	} lts_pulse_state_type;

	lts_pulse_state_type s_q;
	lts_pulse_state_type s_d;

	// set wins when start and stop coincide, so the pulse is never lost
	always_comb begin
		s_d = s_q;
		if (line_cnt == start_cnt) begin
			s_d.pulse = 1'b1;
		end else if (line_cnt == stop_cnt) begin
			s_d.pulse = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pulse_q = s_q.pulse;
endmodule : lts_pulse_gen

/* File: bench/lts_host_model.sv */
// host model: avalon master that configures the line timing block
`timescale 1ns/1ps
module lts_host_model (
	input wire logic clk, // system clock
	input wire logic waitrequest, // slave wait, low on answer
	input wire logic [31:0] readdata, // slave read data
	output logic [7:0] address, // byte address
	output logic read, // read request
	output logic write, // write request
	output logic [31:0] writedata, // write data
	output logic [3:0] byteenable // byte lanes
);
	// idle bus at time zero
	initial begin
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'h0;
	end
	// one access; held until waitrequest is sampled low at an edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge clk);
		address <= a;
		writedata <= d;
		byteenable <= be;
		read <= ~wr;
		write <= wr;
		do @(posedge clk); while (waitrequest !== 1'b0);
		q = readdata;
		// released lines show the inverse so stale values cannot pass
		read <= 1'b0;
		write <= 1'b0;
		address <= ~a;
		writedata <= ~d;
	endtask : xfer
	// normal operation wants the loop filter trim at its nominal value
	task automatic setup();
		logic [31:0] q;
		xfer(1'b1, 8'h40, 32'h20, 4'hf, q);
	endtask : setup
endmodule : lts_host_model

/* File: bench/lts_line_timing_tb.sv */
// self-checking bench for the line timing pulse control block
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
$display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module lts_line_timing_tb;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] e;} lts_row_type;
	localparam int LL = 600; // shortened line
	localparam int RL = 20; // shortened restore width
	logic clk = 1'b0; // system clock
	logic rst_b = 1'b0; // reset, active low
	logic sync_in = 1'b0; // incoming sync
	logic sync_en = 1'b1; // sync source on
	logic [7:0] address; // bus address
	logic read; // bus read
	logic write; // bus write
	logic [31:0] writedata; // bus write data
	logic [3:0] byteenable; // bus lanes
	logic [31:0] readdata; // bus read data
	logic waitrequest; // bus wait
	logic ext_sync_pulse; // sync output
	logic black_level_restore_pulse; // restore pulse
	logic [7:0] loop_filter_adjust; // filter trim
	logic line_locked; // lock flag
	int miscompares = 0; // mismatches
	int num_checks = 0; // comparisons
	int cyc = 0; // cycle count
	int er_t = 0; // last sync out rise
	int er_p = 0; // previous sync out rise
	int ef_t = 0; // last sync out fall
	int rr_t = 0; // last restore rise
	int rf_t = 0; // last restore fall
	logic ep = 1'b0; // previous sync out
	logic rp = 1'b0; // previous restore
	lts_row_type rows [10]; // write, read back
	logic [31:0] rv [8]; // reset values
	logic [31:0] q; // read data
	// 100 mhz clock
	initial begin
		forever #5 clk = ~clk;
	end
	// sync source, one 4-cycle pulse per line while enabled
	initial begin
		forever begin
			repeat (LL - 4) @(posedge clk);
			sync_in <= sync_en;
			repeat (4) @(posedge clk);
			sync_in <= 1'b0;
		end
	end
	// edge time monitor, sampled on the same edges the design uses
	always @(posedge clk) begin
		cyc <= cyc + 1;
		ep <= ext_sync_pulse;
		rp <= black_level_restore_pulse;
		if (ext_sync_pulse && !ep) begin
			er_t <= cyc;
			er_p <= er_t;
		end
		if (!ext_sync_pulse && ep) ef_t <= cyc;
		if (black_level_restore_pulse && !rp) rr_t <= cyc;
		if (!black_level_restore_pulse && rp) rf_t <= cyc;
	end
	lts_host_model host (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable));
	lts_line_timing #(.LINE_LEN(LL), .RESTORE_LEN(RL)) uut (.clk(clk), .rst_b(rst_b),
		.sync_in(sync_in), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .ext_sync_pulse(ext_sync_pulse),
		.black_level_restore_pulse(black_level_restore_pulse),
		.loop_filter_adjust(loop_filter_adjust), .line_locked(line_locked));
	// verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize
	// hang guard, well past the expected length of the run
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		summarize();
	end
	// main sequence
	initial begin
		rv = '{32'h3b, 32'h03, 32'h20, 32'h00, 32'h00, 32'hdd, 32'h3f, 32'h00};
		rows = '{'{8'h30, 32'hffffffa5, 4'hf, 32'ha5}, '{8'h34, 32'hfffffffe, 4'hf, 32'h2},
			'{8'h38, 32'h5a, 4'hf, 32'h5a}, '{8'h3c, 32'hfd, 4'hf, 32'h1},
			'{8'h40, 32'h33, 4'hf, 32'h33}, '{8'h44, 32'h10, 4'hf, 32'h10},
			'{8'h48, 32'h77, 4'hf, 32'h77}, '{8'h4c, 32'hff, 4'hf, 32'h3},
			'{8'h50, 32'hff, 4'hf, 32'h0}, '{8'h30, 32'h11, 4'h0, 32'ha5}};
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		`CHK(loop_filter_adjust, 8'h00)
		for (int i = 0; i < 8; i++) begin
			host.xfer(1'b0, 8'h30 + 8'(4 * i), 32'h0, 4'hf, q);
			`CHK(q, rv[i])
		end
		foreach (rows[i]) begin
			host.xfer(1'b1, rows[i].a, rows[i].d, rows[i].be, q);
			host.xfer(1'b0, rows[i].a, 32'h0, 4'hf, q);
			`CHK(q, rows[i].e)
		end
		host.setup();
		@(posedge clk);
		`CHK(loop_filter_adjust, 8'h20)
		// start 0x020, end 0x040, restore 0x030, window 16
		host.xfer(1'b1, 8'h30, 32'h20, 4'h1, q);
		host.xfer(1'b1, 8'h34, 32'h0, 4'h1, q);
		host.xfer(1'b1, 8'h38, 32'h40, 4'h1, q);
		host.xfer(1'b1, 8'h3c, 32'h0, 4'h1, q);
		host.xfer(1'b1, 8'h48, 32'h30, 4'h1, q);
		host.xfer(1'b1, 8'h4c, 32'h0, 4'h1, q);
		repeat (3 * LL) @(posedge clk);
		@(posedge ext_sync_pulse);
		repeat (100) @(posedge clk);
		`CHK(er_t - er_p, LL)
		`CHK(ef_t - er_t, 32'sd32)
		`CHK(rr_t - er_t, 32'sd16)
		`CHK(rf_t - rr_t, RL)
		`CHK(line_locked, 1'b1)
		// clear the miss count, then let syncs stop after the next line
		host.xfer(1'b1, 8'h60, 32'h0, 4'h1, q);
		@(negedge sync_in);
		sync_en <= 1'b0;
		// with a window of 16 the miss lands 616 counts after the last reference
		repeat (610) @(posedge clk);
		`CHK(line_locked, 1'b1)
		repeat (10) @(posedge clk);
		`CHK(line_locked, 1'b0)
		repeat (380) @(posedge clk);
		host.xfer(1'b0, 8'h60, 32'h0, 4'hf, q);
		`CHK(q, 32'h1)
		// second reset in mid-run restores defaults
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		host.xfer(1'b0, 8'h30, 32'h0, 4'hf, q);
		`CHK(q, 32'h3b)
		`CHK(loop_filter_adjust, 8'h00)
		summarize();
	end
endmodule : lts_line_timing_tb
